// *** usb_xcvr_ctrl.sv ***
// transceiver control register, indirect address/data port and endpoint
// pipe map; assumes the sfr bus is synchronous to clk_i, line pins are not
`default_nettype none
`timescale 1ns/100ps
module usb_xcvr_ctrl
   import usb_xcvr_pkg::*;
(
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       reset_i,
   // sfr bus from cpu
   input  wire sfr_req_t   sfr_req_i,
   output logic      [7:0] sfr_rdata_o,
   // line pins and vbus
   input  wire logic       plus_line_i,
   input  wire logic       minus_line_i,
   input  wire logic       vbus_i,
   // transceiver drive
   output logic            pullup_plus_o,
   output logic            pullup_minus_o,
   output logic            transceiver_on_o,
   output logic            full_speed_o,
   output logic            force_oe_o,
   output logic            force_plus_o,
   output logic            force_minus_o,
   // endpoint steering and pipe map
   output logic      [3:0] endpoint_select_o,
   input  wire logic [7:0] token_ep_addr_i,
   output pipe_hit_t       pipe_hit_o,
   output logic      [7:0] pipe_bytes_o
);
   xcvr_ctrl_t xc_ff;
   ind_state_t state_ff;
   logic       auto_ff;
   logic [5:0] addr_ff;
   logic [7:0] data_ff;
   logic [2:0] pins_sync;
   logic [7:0] core_rdata;
   logic       core_done;

   pin_sync #(.WIDTH(3)) u_pin_sync (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .d_i     ({vbus_i, plus_line_i, minus_line_i}),
      .q_o     (pins_sync)
   );

   wire vbus_seen   = pins_sync[2];
   wire plus_level  = pins_sync[1];
   wire minus_level = pins_sync[0];

   // sfr decode
   wire xc_wr  = sfr_req_i.wr && (sfr_req_i.addr == SFR_XCVR_CTRL);
   wire adr_wr = sfr_req_i.wr && (sfr_req_i.addr == SFR_INDIRECT_ADDR);
   wire dat_wr = sfr_req_i.wr && (sfr_req_i.addr == SFR_INDIRECT_DATA);
   wire dat_rd = sfr_req_i.rd && (sfr_req_i.addr == SFR_INDIRECT_DATA);
   wire busy   = (state_ff == IND_BUSY);

   // explicit start only on a one; auto start only from an idle data read
   wire start_explicit = adr_wr && sfr_req_i.wdata[ADR_BUSY_BIT];
   wire start_auto     = dat_rd && auto_ff && !busy;
   wire start_rd       = start_explicit || start_auto;
   // a read started together with an address load uses the new address
   wire [5:0] core_addr = adr_wr ? sfr_req_i.wdata[5:0] : addr_ff;

   core_reg_bank u_core (
      .clk_i             (clk_i),
      .reset_i           (reset_i),
      .addr_i            (core_addr),
      .wr_i              (dat_wr),
      .wdata_i           (sfr_req_i.wdata),
      .rd_i              (start_rd),
      .rdata_o           (core_rdata),
      .rd_done_o         (core_done),
      .endpoint_select_o (endpoint_select_o)
   );

   // status: diff receiver is only meaningful with the transceiver on
   wire diff_line_state = xc_ff.transceiver_on & plus_level & ~minus_level;
   wire [7:0] xc_view = {xc_ff.pullup_switch, xc_ff.transceiver_on, xc_ff.full_speed,
                         xc_ff.line_test_mode, diff_line_state, plus_level, minus_level};
   wire [7:0] adr_view = {busy, auto_ff, addr_ff};

   wire [7:0] nxt_rdata = (sfr_req_i.addr == SFR_XCVR_CTRL)     ? xc_view  :
                          (sfr_req_i.addr == SFR_INDIRECT_ADDR) ? adr_view :
                          (sfr_req_i.addr == SFR_INDIRECT_DATA) ? data_ff  : 8'h00;

   // busy: a new start wins over completion in the same cycle
   ind_state_t nxt_state;
   always_comb begin
      case (state_ff)
         IND_IDLE: nxt_state = start_rd ? IND_BUSY : IND_IDLE;
         IND_BUSY: nxt_state = (start_rd || !core_done) ? IND_BUSY : IND_IDLE;
         default:  nxt_state = IND_IDLE;
      endcase
   end

   // a cpu data write wins over returning read data; software avoids this by polling
   wire [7:0] nxt_data = dat_wr ? sfr_req_i.wdata : (core_done ? core_rdata : data_ff);

   // pull-up location follows speed, and only with vbus present
   wire pullup_on = xc_ff.pullup_switch & vbus_seen;
   wire nxt_pu_plus  = pullup_on & xc_ff.full_speed;
   wire nxt_pu_minus = pullup_on & ~xc_ff.full_speed;
   wire nxt_f_oe     = (xc_ff.line_test_mode != LINE_NORMAL);
   wire nxt_f_plus   = (xc_ff.line_test_mode == LINE_DIFF1);
   wire nxt_f_minus  = (xc_ff.line_test_mode == LINE_DIFF0);

   // pipe map from protocol address
   pipe_hit_t nxt_hit;
   assign nxt_hit.ep0     = (token_ep_addr_i == EP0_PROTO_ADDR);
   assign nxt_hit.ep1_in  = (token_ep_addr_i == EP1_IN_PROTO_ADDR);
   assign nxt_hit.ep1_out = (token_ep_addr_i == EP1_OUT_PROTO_ADDR);
   wire [7:0] nxt_bytes = nxt_hit.ep0     ? EP0_PIPE_BYTES     :
                          nxt_hit.ep1_in  ? EP1_IN_PIPE_BYTES  :
                          nxt_hit.ep1_out ? EP1_OUT_PIPE_BYTES : 8'h00;

   // status bits 2..0 are never stored, only the writable top five
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         xc_ff <= xcvr_ctrl_t'(XC_CTRL_RESET);
      end else if (xc_wr) begin
         xc_ff <= xcvr_ctrl_t'(sfr_req_i.wdata[7:3]);
      end
   end

   // auto bit and address load together from every address write
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         auto_ff <= 1'b0;
         addr_ff <= ADR_RESET;
      end else if (adr_wr) begin
         auto_ff <= sfr_req_i.wdata[ADR_AUTO_BIT];
         addr_ff <= sfr_req_i.wdata[5:0];
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_ff <= IND_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         data_ff <= DATA_RESET;
      end else begin
         data_ff <= nxt_data;
      end
   end

   // read data stands until the next read of any sfr
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         sfr_rdata_o <= 8'h00;
      end else if (sfr_req_i.rd) begin
         sfr_rdata_o <= nxt_rdata;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         pullup_plus_o <= 1'b0;
      end else begin
         pullup_plus_o <= nxt_pu_plus;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         pullup_minus_o <= 1'b0;
      end else begin
         pullup_minus_o <= nxt_pu_minus;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         transceiver_on_o <= 1'b0;
      end else begin
         transceiver_on_o <= xc_ff.transceiver_on;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         full_speed_o <= 1'b0;
      end else begin
         full_speed_o <= xc_ff.full_speed;
      end
   end

   // test drive is independent of the enable bit, so lines can be forced in suspend
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         force_oe_o <= 1'b0;
      end else begin
         force_oe_o <= nxt_f_oe;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         force_plus_o <= 1'b0;
      end else begin
         force_plus_o <= nxt_f_plus;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         force_minus_o <= 1'b0;
      end else begin
         force_minus_o <= nxt_f_minus;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         pipe_hit_o <= '0;
      end else begin
         pipe_hit_o <= nxt_hit;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         pipe_bytes_o <= 8'h00;
      end else begin
         pipe_bytes_o <= nxt_bytes;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   a_busy_on_start: assert property (start_explicit |=> busy)
      else $error("busy not set after start");
   a_busy_zero_write: assert property (adr_wr && !sfr_req_i.wdata[ADR_BUSY_BIT] && !busy
      && !start_auto |=> !busy)
      else $error("busy set by zero write");
   a_busy_clears_valid: assert property (start_rd ##1 !start_rd |=> !busy
      && data_ff == $past(core_rdata) || $past(dat_wr))
      else $error("busy not cleared with valid data");
   a_auto_restart: assert property (dat_rd && auto_ff && !busy ##1 !start_rd
      |-> busy ##1 !busy)
      else $error("auto read did not restart");
   a_no_auto_manual: assert property (dat_rd && !auto_ff && !busy && !adr_wr |=> !busy)
      else $error("read started without auto");
   a_pullup_plus: assert property (pullup_plus_o == $past(xc_ff.pullup_switch
      && xc_ff.full_speed && vbus_seen))
      else $error("plus pull-up wrong");
   a_pullup_minus: assert property (pullup_minus_o |-> !pullup_plus_o
      && !$past(xc_ff.full_speed) && $past(vbus_seen))
      else $error("minus pull-up wrong");
   a_test_drive: assert property (force_oe_o && !force_plus_o && !force_minus_o
      |-> $past(xc_ff.line_test_mode) == LINE_SE0)
      else $error("line test drive wrong");
   a_diff_off: assert property (!xc_ff.transceiver_on |-> !diff_line_state)
      else $error("diff status while off");
   a_pipe_map: assert property (token_ep_addr_i == EP1_OUT_PROTO_ADDR
      |=> pipe_hit_o.ep1_out && pipe_bytes_o == EP1_OUT_PIPE_BYTES)
      else $error("pipe map wrong");
   a_pipe_ep1_in: assert property (token_ep_addr_i == EP1_IN_PROTO_ADDR
      |=> pipe_hit_o.ep1_in && pipe_bytes_o == EP1_IN_PIPE_BYTES)
      else $error("in pipe map wrong");
   a_pipe_ep0: assert property (token_ep_addr_i == EP0_PROTO_ADDR
      |=> pipe_hit_o.ep0 && !pipe_hit_o.ep1_in && !pipe_hit_o.ep1_out)
      else $error("control pipe map wrong");
   a_xcvr_on_follows: assert property (transceiver_on_o == $past(xc_ff.transceiver_on))
      else $error("transceiver enable output wrong");
   a_speed_follows: assert property (full_speed_o == $past(xc_ff.full_speed))
      else $error("speed output wrong");
   a_pullup_vbus: assert property (pullup_plus_o || pullup_minus_o
      |-> $past(xc_ff.pullup_switch && vbus_seen))
      else $error("pull-up without enable or vbus");
   a_status_pins: assert property (sfr_req_i.rd && sfr_req_i.addr == SFR_XCVR_CTRL
      |=> sfr_rdata_o[1:0] == $past({plus_level, minus_level}))
      else $error("line level status wrong");
   a_addr_load: assert property (adr_wr
      |=> addr_ff == $past(sfr_req_i.wdata[5:0]))
      else $error("target address not loaded");
   a_busy_view: assert property (sfr_req_i.rd && sfr_req_i.addr == SFR_INDIRECT_ADDR
      |=> sfr_rdata_o[ADR_BUSY_BIT] == $past(busy))
      else $error("busy readback wrong");
   a_unmapped_zero: assert property (sfr_req_i.rd && sfr_req_i.addr != SFR_XCVR_CTRL
      && sfr_req_i.addr != SFR_INDIRECT_ADDR && sfr_req_i.addr != SFR_INDIRECT_DATA
      |=> sfr_rdata_o == 8'h00)
      else $error("unmapped sfr read not zero");
   a_data_write: assert property (dat_wr
      |=> data_ff == $past(sfr_req_i.wdata))
      else $error("data register write lost");
   a_force_plus: assert property (force_plus_o |-> force_oe_o && !force_minus_o)
      else $error("plus force drive wrong");
   a_force_minus: assert property (force_minus_o |-> force_oe_o && !force_plus_o)
      else $error("minus force drive wrong");

   c_read_cycle: cover property (start_explicit ##1 busy ##1 !busy);
   c_auto_chain: cover property (start_auto ##2 start_auto);
   c_minus_pullup: cover property (pullup_minus_o);
   c_plus_pullup: cover property (pullup_plus_o && transceiver_on_o);
   c_index_write: cover property (dat_wr && addr_ff == CORE_ENDPOINT_INDEX);
endmodule // usb_xcvr_ctrl
`default_nettype wire

// *** usb_xcvr_pkg.sv ***
// constants, field layouts and carrier types for the transceiver control
// and indirect register port; assumes one 250 MHz clock and an 8-bit sfr bus
// Notes on behaviour
// - three pipes: ep0 0x00, ep1 in 0x81, out 0x01
// - ep1 split: 64 byte in, 128 byte out
// - speed one: full speed, pull-up on plus line
// - speed zero: low speed, pull-up on minus line
// - pull-up needs enable bit and vbus present
// - transceiver enable bit on, zero means suspend
// - line test field forces line drive levels
// - diff status reports bus state while enabled
// - status bits show plus and minus pins
// - core registers reached via address/data pair
// - index register steers indexed register accesses
// - busy write one starts read, zero ignored
// - busy held until data register valid
// - auto read restarts read on data read
// - low six address bits select core register
// - index low nibble selects endpoint, top reads zero
`default_nettype none
package usb_xcvr_pkg;
   // sfr addresses
   localparam logic [7:0] SFR_INDIRECT_ADDR = 8'h96;
   localparam logic [7:0] SFR_INDIRECT_DATA = 8'h97;
   localparam logic [7:0] SFR_XCVR_CTRL     = 8'hd7;
   // transceiver_control fields
   localparam int XC_PULLUP_BIT = 7;
   localparam int XC_ON_BIT     = 6;
   localparam int XC_SPEED_BIT  = 5;
   localparam int XC_TEST_LSB   = 3;
   localparam int XC_DIFF_BIT   = 2;
   localparam int XC_PLUS_BIT   = 1;
   localparam int XC_MINUS_BIT  = 0;
   localparam logic [4:0] XC_CTRL_RESET = 5'h00;
   // indirect_address fields
   localparam int ADR_BUSY_BIT = 7;
   localparam int ADR_AUTO_BIT = 6;
   localparam logic [5:0] ADR_RESET  = 6'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;
   // core register space
   localparam logic [5:0] CORE_ENDPOINT_INDEX = 6'h0e;
   localparam logic [5:0] CORE_INDEXED_LO     = 6'h10;
   localparam logic [5:0] CORE_INDEXED_HI     = 6'h17;
   localparam logic [3:0] INDEX_RESET         = 4'h0;
   localparam logic [3:0] EP_NUM_0            = 4'h0;
   localparam logic [3:0] EP_NUM_1            = 4'h1;
   // endpoint protocol addresses and pipe sizes
   localparam logic [7:0] EP0_PROTO_ADDR     = 8'h00;
   localparam logic [7:0] EP1_IN_PROTO_ADDR  = 8'h81;
   localparam logic [7:0] EP1_OUT_PROTO_ADDR = 8'h01;
   localparam logic [7:0] EP0_PIPE_BYTES     = 8'h40;
   localparam logic [7:0] EP1_IN_PIPE_BYTES  = 8'h40;
   localparam logic [7:0] EP1_OUT_PIPE_BYTES = 8'h80;

   typedef enum logic [1:0] {
      LINE_NORMAL = 2'b00,
      LINE_DIFF1  = 2'b01,
      LINE_DIFF0  = 2'b10,
      LINE_SE0    = 2'b11
   } line_test_mode_t;

   typedef enum logic {
      IND_IDLE = 1'b0,
      IND_BUSY = 1'b1
   } ind_state_t;

   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } sfr_req_t;

   typedef struct packed {
      logic            pullup_switch;
      logic            transceiver_on;
      logic            full_speed;
      line_test_mode_t line_test_mode;
   } xcvr_ctrl_t;

   typedef struct packed {
      logic ep0;
      logic ep1_in;
      logic ep1_out;
   } pipe_hit_t;
endpackage
`default_nettype wire

// *** pin_sync.sv ***
// three-stage pin synchroniser; output moves once stages two and three agree
// assumes inputs asynchronous to clk_i
`default_nettype none
`timescale 1ns/100ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             reset_i,
   // pins
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] s1_ff;
   logic [WIDTH-1:0] s2_ff;
   logic [WIDTH-1:0] s3_ff;
   wire  [WIDTH-1:0] agree = ~(s2_ff ^ s3_ff);
   wire  [WIDTH-1:0] nxt_q = (agree & s3_ff) | (~agree & q_o);

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         q_o   <= '0;
      end else begin
         s1_ff <= d_i;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         q_o   <= nxt_q;
      end
   end
endmodule // pin_sync
`default_nettype wire

// *** core_reg_bank.sv ***
// core register space behind the indirect port: endpoint index and the
// per-endpoint indexed registers; other core registers live elsewhere
// assumes single-cycle requests from the indirect port logic
`default_nettype none
`timescale 1ns/100ps
module core_reg_bank
   import usb_xcvr_pkg::*;
(
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       reset_i,
   // core access
   input  wire logic [5:0] addr_i,
   input  wire logic       wr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       rd_i,
   output logic      [7:0] rdata_o,
   output logic            rd_done_o,
   // endpoint steering
   output logic      [3:0] endpoint_select_o
);
   logic [7:0] ep_regs [0:1][0:7];
   wire is_index   = (addr_i == CORE_ENDPOINT_INDEX);
   wire is_indexed = (addr_i >= CORE_INDEXED_LO) && (addr_i <= CORE_INDEXED_HI);
   wire sel_valid  = (endpoint_select_o == EP_NUM_0) || (endpoint_select_o == EP_NUM_1);
   wire ep_bit     = endpoint_select_o[0];
   wire [7:0] idx_val = ep_regs[ep_bit][addr_i[2:0]];
   wire [7:0] nxt_rdata = is_index ? {4'h0, endpoint_select_o} :
                          (is_indexed && sel_valid) ? idx_val : 8'h00;

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         endpoint_select_o <= INDEX_RESET;
         rdata_o           <= 8'h00;
         rd_done_o         <= 1'b0;
      end else begin
         if (wr_i && is_index)
            endpoint_select_o <= wdata_i[3:0];
         rd_done_o <= rd_i;
         if (rd_i)
            rdata_o <= nxt_rdata;
      end
   end

   // reserved selections never land in storage
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         for (int e = 0; e < 2; e++)
            for (int r = 0; r < 8; r++)
               ep_regs[e][r] <= 8'h00;
      end else if (wr_i && is_indexed && sel_valid) begin
         ep_regs[ep_bit][addr_i[2:0]] <= wdata_i;
      end
   end

   a_index_upper_zero: assert property (@(posedge clk_i) disable iff (reset_i)
      rd_i && is_index |=> rdata_o[7:4] == 4'h0)
      else $error("index upper bits not zero");
   a_reserved_reads_zero: assert property (@(posedge clk_i) disable iff (reset_i)
      rd_i && is_indexed && !sel_valid |=> rdata_o == 8'h00 && rd_done_o)
      else $error("reserved endpoint read not zero");
endmodule // core_reg_bank
`default_nettype wire

// *** usb_line_model.sv ***
// bus-side partner: the two data lines and vbus as the host end sees them
// assumes the host holds both lines low through pull-downs when nobody drives
`timescale 1ns/100ps
`default_nettype none
module usb_line_model (
   // device drive
   input  wire logic pullup_plus_i,
   input  wire logic pullup_minus_i,
   input  wire logic force_oe_i,
   input  wire logic force_plus_i,
   input  wire logic force_minus_i,
   // host controls
   input  wire logic host_oe_i,
   input  wire logic host_plus_i,
   input  wire logic host_minus_i,
   input  wire logic vbus_on_i,
   // lines
   output logic      plus_o,
   output logic      minus_o,
   output logic      vbus_o
);
   // a forced device drive beats the host; released lines fall to the pull-downs
   // unless the device pull-up holds one high
   assign plus_o  = force_oe_i ? force_plus_i : (host_oe_i ? host_plus_i : pullup_plus_i);
   assign minus_o = force_oe_i ? force_minus_i : (host_oe_i ? host_minus_i : pullup_minus_i);
   assign vbus_o  = vbus_on_i;
endmodule // usb_line_model
`default_nettype wire

// *** tb.sv ***
// self-checking bench for the transceiver control and indirect port
// assumes the usb clock runs for the whole run, so every access is legal
`timescale 1ns/100ps
`default_nettype none
module tb
   import usb_xcvr_pkg::*;
;
   logic       clk_i = 1'b0;
   logic       reset_i = 1'b1;
   sfr_req_t   req = '0;
   logic [7:0] rdata, token_ep = 8'h00, pipe_bytes;
   logic       pup_plus, pup_minus, xcvr_on, fs, f_oe, f_plus, f_minus;
   logic       plus_line, minus_line, vbus;
   logic       host_oe = 1'b0, host_plus = 1'b0, host_minus = 1'b0, vbus_on = 1'b1;
   logic [3:0] ep_sel;
   pipe_hit_t  pipe_hit;
   int         fails = 0;
   int         compares = 0;
   logic [7:0] ep_addr [4] = '{8'h00, 8'h81, 8'h01, 8'h02};
   logic [7:0] hit_exp [4] = '{8'h04, 8'h02, 8'h01, 8'h00};
   logic [7:0] size_exp [4] = '{8'h40, 8'h40, 8'h80, 8'h00};

   always #2 clk_i = ~clk_i; // usb clock runs before and during every access

   usb_xcvr_ctrl dut (.clk_i(clk_i), .reset_i(reset_i), .sfr_req_i(req), .sfr_rdata_o(rdata),
      .plus_line_i(plus_line), .minus_line_i(minus_line), .vbus_i(vbus), .pullup_plus_o(pup_plus),
      .pullup_minus_o(pup_minus), .transceiver_on_o(xcvr_on), .full_speed_o(fs), .force_oe_o(f_oe),
      .force_plus_o(f_plus), .force_minus_o(f_minus), .endpoint_select_o(ep_sel),
      .token_ep_addr_i(token_ep), .pipe_hit_o(pipe_hit), .pipe_bytes_o(pipe_bytes));

   usb_line_model host (.pullup_plus_i(pup_plus), .pullup_minus_i(pup_minus), .force_oe_i(f_oe),
      .force_plus_i(f_plus), .force_minus_i(f_minus), .host_oe_i(host_oe), .host_plus_i(host_plus),
      .host_minus_i(host_minus), .vbus_on_i(vbus_on), .plus_o(plus_line), .minus_o(minus_line),
      .vbus_o(vbus));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   function automatic sfr_req_t w(input logic [7:0] a, input logic [7:0] v);
      return '{a, 1'b1, 1'b0, v};
   endfunction

   function automatic sfr_req_t rq(input logic [7:0] a);
      return '{a, 1'b0, 1'b1, 8'h00};
   endfunction

   // two requests on consecutive edges; returns read data after the second
   task automatic bus(input sfr_req_t r1, input sfr_req_t r2, output logic [7:0] d);
      @(posedge clk_i);
      req <= r1;
      @(posedge clk_i);
      req <= r2;
      @(posedge clk_i);
      req <= '0;
      #1 d = rdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      logic [7:0] d;
      bus(w(a, v), '0, d);
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      bus(rq(a), '0, d);
   endtask

   task automatic wait_idle;
      logic [7:0] s;
      s = 8'h80;
      for (int n = 0; n < 20 && s[7] !== 1'b0; n++) rd(SFR_INDIRECT_ADDR, s);
      if (s[7] !== 1'b0) begin
         fails++;
         $display("unexpected at %0t: busy never cleared", $time);
      end
   endtask

   task automatic core_wr(input logic [7:0] a, input logic [7:0] v);
      wait_idle();
      wr(SFR_INDIRECT_ADDR, a);
      wr(SFR_INDIRECT_DATA, v);
   endtask

   task automatic core_rd(input logic [7:0] a, output logic [7:0] d);
      wait_idle();
      wr(SFR_INDIRECT_ADDR, 8'h80 | a);
      wait_idle();
      rd(SFR_INDIRECT_DATA, d);
   endtask

   // pin synchronisers need several edges before status bits move
   task automatic settle;
      repeat (8) @(posedge clk_i);
      #1;
   endtask

   task automatic finish_test;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      #80000;
      fails++;
      $display("unexpected at %0t: watchdog expired", $time);
      finish_test();
   end

   initial begin
      logic [7:0] d;
      repeat (8) @(posedge clk_i);
      reset_i <= 1'b0;
      rd(SFR_XCVR_CTRL, d); check(d, 8'h00);
      rd(SFR_INDIRECT_DATA, d); check(d, 8'h00);
      rd(8'h55, d); check(d, 8'h00);
      $display("test reset done");
      wr(SFR_XCVR_CTRL, 8'he7);
      settle(); check({4'h0, pup_plus, pup_minus, xcvr_on, fs}, 8'h0b);
      rd(SFR_XCVR_CTRL, d); check(d, 8'he6);
      @(posedge clk_i);
      vbus_on <= 1'b0;
      settle(); check({6'h00, pup_plus, pup_minus}, 8'h00);
      rd(SFR_XCVR_CTRL, d); check(d, 8'he0);
      @(posedge clk_i);
      vbus_on <= 1'b1;
      wr(SFR_XCVR_CTRL, 8'hc0);
      settle(); check({5'h00, pup_plus, pup_minus, fs}, 8'h02);
      rd(SFR_XCVR_CTRL, d); check(d, 8'hc1);
      wr(SFR_XCVR_CTRL, 8'h40);
      settle(); check({6'h00, pup_plus, pup_minus}, 8'h00);
      @(posedge clk_i);
      host_oe <= 1'b1;
      host_plus <= 1'b1;
      wr(SFR_XCVR_CTRL, 8'h20);
      settle(); check({7'h00, xcvr_on}, 8'h00);
      rd(SFR_XCVR_CTRL, d); check(d, 8'h22);
      wr(SFR_XCVR_CTRL, 8'h60);
      settle(); rd(SFR_XCVR_CTRL, d); check(d, 8'h66);
      @(posedge clk_i);
      host_plus <= 1'b0;
      host_minus <= 1'b1;
      settle(); rd(SFR_XCVR_CTRL, d); check(d, 8'h61);
      @(posedge clk_i);
      host_oe <= 1'b0;
      for (int m = 0; m < 4; m++) begin
         wr(SFR_XCVR_CTRL, {3'b010, m[1:0], 3'b000});
         settle(); check({f_oe, f_plus, f_minus}, {5'h00, m != 0, m == 1, m == 2});
         rd(SFR_XCVR_CTRL, d); check(d, {3'b010, m[1:0], m == 1, m == 1, m == 2});
      end
      $display("test transceiver done");
      core_wr(8'h0e, 8'hf1);
      settle(); check({4'h0, ep_sel}, 8'h01);
      core_rd(8'h0e, d); check(d, 8'h01);
      bus(w(SFR_INDIRECT_ADDR, 8'h8e), rq(SFR_INDIRECT_ADDR), d); check(d, 8'h8e);
      wait_idle();
      rd(SFR_INDIRECT_DATA, d); check(d, 8'h01);
      wr(SFR_INDIRECT_ADDR, 8'h11);
      rd(SFR_INDIRECT_DATA, d); check(d, 8'h01);
      rd(SFR_INDIRECT_ADDR, d); check(d, 8'h11);
      $display("test indirect done");
      core_wr(8'h0e, 8'h00);
      core_wr(8'h11, 8'ha5);
      core_wr(8'h0e, 8'h01);
      core_wr(8'h11, 8'h5a);
      core_rd(8'h11, d); check(d, 8'h5a);
      core_wr(8'h0e, 8'h05);
      core_rd(8'h0e, d); check(d, 8'h05);
      core_wr(8'h11, 8'hff);
      core_rd(8'h11, d); check(d, 8'h00);
      core_wr(8'h0e, 8'h00);
      core_rd(8'h11, d); check(d, 8'ha5);
      core_wr(8'h0e, 8'h01);
      core_rd(8'h11, d); check(d, 8'h5a);
      $display("test indexed done");
      wr(SFR_INDIRECT_ADDR, 8'hd1);
      wait_idle();
      bus(rq(SFR_INDIRECT_DATA), rq(SFR_INDIRECT_ADDR), d); check(d, 8'hd1);
      wait_idle();
      rd(SFR_INDIRECT_DATA, d); check(d, 8'h5a);
      wait_idle();
      wr(SFR_INDIRECT_ADDR, 8'h11);
      bus(rq(SFR_INDIRECT_DATA), rq(SFR_INDIRECT_ADDR), d); check(d, 8'h11);
      $display("test auto read done");
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_i);
         token_ep <= ep_addr[i];
         repeat (2) @(posedge clk_i);
         #1 check({5'h00, pipe_hit}, hit_exp[i]);
         check(pipe_bytes, size_exp[i]);
      end
      $display("test pipes done");
      @(posedge clk_i);
      reset_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      rd(SFR_XCVR_CTRL, d); check(d & 8'hf8, 8'h00);
      core_rd(8'h0e, d); check(d, 8'h00);
      $display("test second reset done");
      finish_test();
   end
endmodule // tb
`default_nettype wire
